// file: fac_pkg.sv
// flicker avoidance control: shared constants, register map and carriers
// assumes one 125 MHz system clock and a plain strobe register port
package fac_pkg;
  localparam int unsigned FAC_CLK_HZ = 125000000;
  localparam int unsigned FAC_AW = 4;
  // register offsets (word index on the plain port)
  localparam logic [3:0] FAC_REG_STEP_SIXTY = 4'h0;
  localparam logic [3:0] FAC_REG_STEP_FIFTY = 4'h1;
  localparam logic [3:0] FAC_REG_SRCH_LOW_FIFTY = 4'h2;
  localparam logic [3:0] FAC_REG_SRCH_HIGH_FIFTY = 4'h3;
  localparam logic [3:0] FAC_REG_SRCH_LOW_SIXTY = 4'h4;
  localparam logic [3:0] FAC_REG_SRCH_HIGH_SIXTY = 4'h5;
  localparam logic [3:0] FAC_REG_DETECT_MIN = 4'h6;
  localparam logic [3:0] FAC_REG_DETECT_RUN = 4'h7;
  localparam logic [3:0] FAC_REG_MODE = 4'h8;
  localparam logic [3:0] FAC_REG_AE_STEP = 4'h9;
  localparam logic [3:0] FAC_REG_WIN_POS = 4'ha;
  localparam logic [3:0] FAC_REG_WIN_HEIGHT = 4'hb;
  localparam logic [3:0] FAC_REG_CTRL = 4'hc;
  // mode word fields
  localparam int unsigned FAC_MODE_SEL_BIT = 5;
  localparam int unsigned FAC_MODE_MANSEL_BIT = 6;
  localparam int unsigned FAC_MODE_MANUAL_BIT = 7;
  // control word fields
  localparam int unsigned FAC_CTRL_EN_BIT = 0;
  localparam int unsigned FAC_CTRL_CAPT_BIT = 1;
  // reset values
  localparam logic [15:0] FAC_RST_STEP_SIXTY = 16'h0000;
  localparam logic [15:0] FAC_RST_STEP_FIFTY = 16'h0000;
  localparam logic [7:0] FAC_RST_DETECT_MIN = 8'h03;
  localparam logic [7:0] FAC_RST_DETECT_RUN = 8'h04;
  localparam logic [7:0] FAC_RST_MODE = 8'h00;
  localparam logic [7:0] FAC_RST_WIN_HEIGHT = 8'h10;
  // one frame's spectral result from the analysis front end
  typedef struct packed {
    logic valid;
    logic [15:0] peak;
  } fac_frame_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [FAC_AW-1:0] addr;
    logic [15:0] wdata;
  } fac_req_t;
endpackage

// file: fac_run_counter.sv
`timescale 1ns/1ps
// fac_run_counter: sliding run of frames, counts frames that held a hit
// assumes i_frame pulses once per frame with i_hit valid beside it
module fac_run_counter
  import fac_pkg::*;
#(
  parameter int unsigned RUN_MAX = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // per-frame input
  input wire logic i_clear,
  input wire logic i_frame,
  input wire logic i_hit,
  input wire logic [7:0] i_run_len,
  input wire logic [7:0] i_min_cnt,
  // result
  output logic o_detect
);
  logic [RUN_MAX-1:0] hist_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  function automatic logic [7:0] fac_popcount(input logic [RUN_MAX-1:0] v,
                                              input logic [7:0] len);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < RUN_MAX; i++) begin
      if (i < int'(len) && v[i]) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction

  // history of the last RUN_MAX frames, newest in bit 0
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear) begin
      hist_q <= '0;
    end else if (i_frame) begin
      hist_q <= {hist_q[RUN_MAX-2:0], i_hit};
    end
  end

  assign cnt_d = fac_popcount({hist_q[RUN_MAX-2:0], i_hit}, i_run_len);

  // count only over the last i_run_len frames
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear) begin
      cnt_q <= 8'h00;
    end else if (i_frame) begin
      cnt_q <= cnt_d;
    end
  end

  // pulse in the cycle after a frame whose window met the threshold
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear) begin
      o_detect <= 1'b0;
    end else begin
      o_detect <= i_frame && (i_min_cnt != 8'h00) && (cnt_d >= i_min_cnt);
    end
  end

  property p_det_cause;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_detect |-> $past(i_frame) && (cnt_q >= i_min_cnt);
  endproperty
  a_det_cause: assert property (p_det_cause) else $error("detect without enough hits");
endmodule

// file: fac_flicker_ctrl.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// fac_flicker_ctrl: flicker detection and integration step selection
// assumes an upstream analyser delivers one peak per frame on i_frame
//
// Operation
// - detect on min hits within frame run
// - automatic after reset, bit five shows selection
// - bit seven manual, bit six picks frequency
// - selected frequency loads matching step into AE
// - integration step stays a whole flicker period
// - capture keeps preview selection, no detection
module fac_flicker_ctrl
  import fac_pkg::*;
#(
  parameter int unsigned RUN_MAX = 16,
  parameter logic [7:0] WIN_STRIDE = 8'h08
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // register port
  input wire fac_req_t i_req,
  output logic [15:0] o_rdata,
  // per-frame analysis
  input wire fac_frame_t i_frame,
  // auto exposure
  output logic [15:0] o_ae_step,
  output logic o_ae_step_load,
  output logic o_sel_sixty,
  // sampling window to analyser
  output logic [7:0] o_win_pos,
  output logic [7:0] o_win_height
);
  logic [15:0] step_rows_sixty_q;
  logic [15:0] step_rows_fifty_q;
  logic [15:0] search_low_fifty_q;
  logic [15:0] search_high_fifty_q;
  logic [15:0] search_low_sixty_q;
  logic [15:0] search_high_sixty_q;
  logic [7:0] detect_min_count_q;
  logic [7:0] detect_frame_run_q;
  logic [7:0] flicker_mode_word_q;
  logic [1:0] ctrl_q;
  logic hunt_sixty_q;
  logic detect;
  logic hit;
  logic detect_on;
  logic manual;
  logic want_sixty;
  logic [7:0] run_len;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic wr_at(input fac_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // host-owned configuration words; their values are the host's duty
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      step_rows_sixty_q <= FAC_RST_STEP_SIXTY;
      step_rows_fifty_q <= FAC_RST_STEP_FIFTY;
      search_low_fifty_q <= 16'h0000;
      search_high_fifty_q <= 16'h0000;
      search_low_sixty_q <= 16'h0000;
      search_high_sixty_q <= 16'h0000;
      detect_min_count_q <= FAC_RST_DETECT_MIN;
      detect_frame_run_q <= FAC_RST_DETECT_RUN;
      ctrl_q <= 2'h0;
    end else begin
      if (wr_at(i_req, FAC_REG_STEP_SIXTY)) step_rows_sixty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_STEP_FIFTY)) step_rows_fifty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_SRCH_LOW_FIFTY)) search_low_fifty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_SRCH_HIGH_FIFTY)) search_high_fifty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_SRCH_LOW_SIXTY)) search_low_sixty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_SRCH_HIGH_SIXTY)) search_high_sixty_q <= i_req.wdata;
      if (wr_at(i_req, FAC_REG_DETECT_MIN)) detect_min_count_q <= i_req.wdata[7:0];
      if (wr_at(i_req, FAC_REG_DETECT_RUN)) detect_frame_run_q <= i_req.wdata[7:0];
      if (wr_at(i_req, FAC_REG_CTRL)) ctrl_q <= i_req.wdata[1:0];
    end
  end

  assign manual = flicker_mode_word_q[FAC_MODE_MANUAL_BIT];
  // detection only with sequencer enable, automatic mode, and not in capture
  assign detect_on = ctrl_q[FAC_CTRL_EN_BIT] && !ctrl_q[FAC_CTRL_CAPT_BIT]
    && !manual;
  // run length clamped to the history depth
  assign run_len = (detect_frame_run_q > 8'(RUN_MAX)) ? 8'(RUN_MAX) : detect_frame_run_q;
  // hunt for the frequency not currently selected; a peak in its band counts
  assign hit = hunt_sixty_q ? in_range(i_frame.peak, search_low_sixty_q, search_high_sixty_q)
    : in_range(i_frame.peak, search_low_fifty_q, search_high_fifty_q);

  fac_run_counter #(
    .RUN_MAX(RUN_MAX)
  ) u_run (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clear(!detect_on || detect),
    .i_frame(i_frame.valid && detect_on),
    .i_hit(hit),
    .i_run_len(run_len),
    .i_min_cnt(detect_min_count_q),
    .o_detect(detect)
  );

  // searched band follows the opposite of the selection
  assign want_sixty = manual ? flicker_mode_word_q[FAC_MODE_MANSEL_BIT]
    : (detect ? hunt_sixty_q : flicker_mode_word_q[FAC_MODE_SEL_BIT]);

  // mode word: bit 7 manual, bit 6 manual choice, bit 5 current selection
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flicker_mode_word_q <= FAC_RST_MODE; // automatic after reset
    end else begin
      flicker_mode_word_q[FAC_MODE_SEL_BIT] <= want_sixty;
      if (wr_at(i_req, FAC_REG_MODE)) begin
        flicker_mode_word_q[7:6] <= i_req.wdata[7:6];
      end
    end
  end

  // hunt band is the one not selected; held steady otherwise
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hunt_sixty_q <= 1'b1;
    end else begin
      hunt_sixty_q <= !want_sixty;
    end
  end

  // step follows selection, reloaded on any selection change or change of the selected band's step
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ae_step <= FAC_RST_STEP_FIFTY;
      o_ae_step_load <= 1'b0;
      o_sel_sixty <= 1'b0;
    end else begin
      o_sel_sixty <= want_sixty;
      o_ae_step <= want_sixty ? step_rows_sixty_q : step_rows_fifty_q;
      o_ae_step_load <= (want_sixty != o_sel_sixty)
        || (o_ae_step != (want_sixty ? step_rows_sixty_q : step_rows_fifty_q));
    end
  end

  // sampling window walks down each frame while detection is on; host writes are ignored
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_win_pos <= 8'h00;
      o_win_height <= FAC_RST_WIN_HEIGHT;
    end else if (i_frame.valid && detect_on) begin
      o_win_pos <= o_win_pos + WIN_STRIDE;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        FAC_REG_STEP_SIXTY: o_rdata <= step_rows_sixty_q;
        FAC_REG_STEP_FIFTY: o_rdata <= step_rows_fifty_q;
        FAC_REG_SRCH_LOW_FIFTY: o_rdata <= search_low_fifty_q;
        FAC_REG_SRCH_HIGH_FIFTY: o_rdata <= search_high_fifty_q;
        FAC_REG_SRCH_LOW_SIXTY: o_rdata <= search_low_sixty_q;
        FAC_REG_SRCH_HIGH_SIXTY: o_rdata <= search_high_sixty_q;
        FAC_REG_DETECT_MIN: o_rdata <= {8'h00, detect_min_count_q};
        FAC_REG_DETECT_RUN: o_rdata <= {8'h00, detect_frame_run_q};
        FAC_REG_MODE: o_rdata <= {8'h00, flicker_mode_word_q};
        FAC_REG_AE_STEP: o_rdata <= o_ae_step;
        FAC_REG_WIN_POS: o_rdata <= {8'h00, o_win_pos};
        FAC_REG_WIN_HEIGHT: o_rdata <= {8'h00, o_win_height};
        FAC_REG_CTRL: o_rdata <= {14'h0000, ctrl_q};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  sequence s_manual_set;
    manual && !$past(manual);
  endsequence

  property p_manual_follow;
    @(posedge i_clk_sys) disable iff (i_rst)
    s_manual_set ##1 manual |-> flicker_mode_word_q[FAC_MODE_SEL_BIT]
      == $past(flicker_mode_word_q[FAC_MODE_MANSEL_BIT]);
  endproperty
  a_manual_follow: assert property (p_manual_follow) else $error("manual pick missed");

  property p_step_match;
    @(posedge i_clk_sys) disable iff (i_rst)
    $stable(step_rows_sixty_q) && $stable(step_rows_fifty_q) && $stable(want_sixty)
      |=> o_ae_step == (o_sel_sixty ? $past(step_rows_sixty_q) : $past(step_rows_fifty_q));
  endproperty
  a_step_match: assert property (p_step_match) else $error("ae step mismatch");

  property p_whole_period;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_sel_sixty |-> o_ae_step == $past(step_rows_sixty_q);
  endproperty
  a_whole_period: assert property (p_whole_period) else $error("step not sixty period");

  property p_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
    // a detect pulse flips the selection on the following edge, so look one cycle back
    !manual && !$past(detect) && $past(!manual)
      |-> $stable(flicker_mode_word_q[FAC_MODE_SEL_BIT]);
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed without detect");

  property p_capture_quiet;
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_q[FAC_CTRL_CAPT_BIT] |=> !detect;
  endproperty
  a_capture_quiet: assert property (p_capture_quiet) else $error("detect in capture");

  property p_auto_reset;
    @(posedge i_clk_sys) $fell(i_rst) |-> !manual;
  endproperty
  a_auto_reset: assert property (p_auto_reset) else $error("not automatic after reset");

  property p_detect_flips;
    @(posedge i_clk_sys) disable iff (i_rst)
    detect && !manual |=> flicker_mode_word_q[FAC_MODE_SEL_BIT]
      != $past(flicker_mode_word_q[FAC_MODE_SEL_BIT]);
  endproperty
  a_detect_flips: assert property (p_detect_flips) else $error("detect did not switch");

  property p_en_needed;
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_q[FAC_CTRL_EN_BIT] |=> !detect;
  endproperty
  a_en_needed: assert property (p_en_needed) else $error("detect while disabled");
endmodule

// file: fac_frame_src.sv
`timescale 1ns/1ps
// fac_frame_src: far-side analyser model, one frame result per request
// assumes the bench spaces requests several cycles apart, as rolling bars would
module fac_frame_src
  import fac_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // request from bench
  input wire logic i_send,
  input wire logic [15:0] i_peak,
  // frame result to block
  output fac_frame_t o_frame
);
  // one-cycle valid per frame; between frames peak is inverted every cycle, so the old value returns every other cycle with valid low
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_frame <= '0;
    end else if (i_send) begin
      o_frame <= {1'b1, i_peak};
    end else begin
      o_frame <= {1'b0, ~o_frame.peak};
    end
  end
endmodule

// file: fac_flicker_ctrl_tb_top.sv
`timescale 1ns/1ps
// fac_flicker_ctrl_tb_top: self-checking bench for the flicker controller
// assumes the frame model file is compiled first; one 125 MHz clock
module fac_flicker_ctrl_tb_top;
  import fac_pkg::*;
  logic i_clk_sys;
  logic i_rst;
  fac_req_t req;
  logic [15:0] o_rdata;
  fac_frame_t frame;
  logic [15:0] o_ae_step;
  logic o_ae_step_load;
  logic o_sel_sixty;
  logic [7:0] o_win_pos;
  logic [7:0] o_win_height;
  logic send;
  logic [15:0] peak;
  int err_total;
  int total_checks;
  int load_cnt;
  int l0;
  fac_flicker_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req),
    .o_rdata(o_rdata), .i_frame(frame), .o_ae_step(o_ae_step),
    .o_ae_step_load(o_ae_step_load), .o_sel_sixty(o_sel_sixty),
    .o_win_pos(o_win_pos), .o_win_height(o_win_height));
  fac_frame_src u_src (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_send(send), .i_peak(peak),
    .o_frame(frame));
  // clock
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // count load pulses so silent frames can be proven silent
  always @(posedge i_clk_sys) begin
    if (o_ae_step_load === 1'b1) load_cnt++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    req <= {1'b1, 1'b0, a, d};
    @(posedge i_clk_sys);
    req <= '0;
  endtask
  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk_sys);
    req <= '0;
    #1 d = o_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic frm(input logic [15:0] p);
    @(posedge i_clk_sys);
    send <= 1'b1;
    peak <= p;
    @(posedge i_clk_sys);
    send <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
  endtask
  // outputs and the load count against expectations
  task automatic outs(input logic [15:0] step, input logic sel, input int loads);
    chk(o_ae_step, step);
    chk({15'h0000, o_sel_sixty}, {15'h0000, sel});
    chk(16'(load_cnt - l0), 16'(loads));
  endtask
  task automatic t_reset;
    rchk(FAC_REG_DETECT_MIN, 16'h0003);
    rchk(FAC_REG_DETECT_RUN, 16'h0004);
    rchk(FAC_REG_MODE, 16'h0000);
    rchk(FAC_REG_WIN_HEIGHT, 16'h0010);
    rchk(4'hd, 16'h0000);
    chk({8'h00, o_win_height}, 16'h0010);
    outs(16'h0000, 1'b0, 0);
  endtask
  task automatic t_setup;
    wr(FAC_REG_STEP_SIXTY, 16'h0104);
    wr(FAC_REG_STEP_FIFTY, 16'h0138);
    wr(FAC_REG_SRCH_LOW_FIFTY, 16'h0033);
    wr(FAC_REG_SRCH_HIGH_FIFTY, 16'h0035);
    wr(FAC_REG_SRCH_LOW_SIXTY, 16'h003d);
    wr(FAC_REG_SRCH_HIGH_SIXTY, 16'h003f);
    wr(FAC_REG_CTRL, 16'h0001);
    rchk(FAC_REG_STEP_FIFTY, 16'h0138);
  endtask
  // two hits in a run of four must not select; the third inside the run must
  task automatic t_auto;
    l0 = load_cnt;
    frm(16'h003e);
    frm(16'h0010);
    frm(16'h003e);
    frm(16'h0010);
    frm(16'h003e);
    outs(16'h0138, 1'b0, 0);
    frm(16'h003e);
    outs(16'h0104, 1'b1, 1);
    rchk(FAC_REG_WIN_POS, 16'h0030);
    rchk(FAC_REG_MODE, 16'h0020);
    rchk(FAC_REG_AE_STEP, 16'h0104);
  endtask
  // capture freezes the choice; back in preview the other band is found
  task automatic t_capture;
    l0 = load_cnt;
    wr(FAC_REG_CTRL, 16'h0003);
    repeat (4) frm(16'h0034);
    outs(16'h0104, 1'b1, 0);
    wr(FAC_REG_CTRL, 16'h0001);
    repeat (3) frm(16'h0034);
    outs(16'h0138, 1'b0, 1);
  endtask
  task automatic t_manual;
    l0 = load_cnt;
    wr(FAC_REG_MODE, 16'h00c0);
    repeat (3) @(posedge i_clk_sys);
    outs(16'h0104, 1'b1, 1);
    rchk(FAC_REG_MODE, 16'h00e0);
    wr(FAC_REG_MODE, 16'h0080);
    repeat (3) frm(16'h0034);
    outs(16'h0138, 1'b0, 2);
    rchk(FAC_REG_MODE, 16'h0080);
    wr(FAC_REG_MODE, 16'h0000);
    rchk(FAC_REG_MODE, 16'h0000);
  endtask
  // window height and AE step registers are read-only to software
  task automatic t_ro;
    wr(FAC_REG_WIN_HEIGHT, 16'h00ff);
    wr(FAC_REG_AE_STEP, 16'h1234);
    rchk(FAC_REG_WIN_HEIGHT, 16'h0010);
    rchk(FAC_REG_AE_STEP, 16'h0138);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 255 cycles of traffic
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    i_rst = 1'b1;
    req = '0;
    send = 1'b0;
    peak = 16'h0000;
    err_total = 0;
    total_checks = 0;
    load_cnt = 0;
    l0 = 0;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset();
    t_setup();
    t_auto();
    t_capture();
    t_manual();
    t_ro();
    results();
  end
endmodule
